// ==== hdl/rfcm_coll_trk.sv ====
// Tracks the first collision and clears bits that follow it
`timescale 1ns/1ps
`include "rfcm_map.svh"
module rfcm_coll_trk (
  input wire logic clk_sys,
  input wire logic rst,
  rfcm_link_if.coll lnk
);
  import rfcm_pkg::*;
  rfcm_coll_s s_q;  // Registered state
  rfcm_coll_s s_d;  // Next state
  logic [5:0] num;  // Position of current bit
  // Next state of the tracker
  always_comb begin
    s_d = s_q;
    s_d.ovalid = 1'b0;
    num = (s_q.cnt == `RFCM_CNT_MAX) ? s_q.cnt : s_q.cnt + 6'h01;
    if (lnk.frame_start) begin
      s_d.cnt = 6'h00;
      s_d.seen = 1'b0;
      s_d.inv = 1'b1;
    end else if (lnk.bit_valid) begin
      s_d.cnt = num;
      s_d.ovalid = 1'b1;
      // Zero every bit after the collision unless kept
      s_d.obit = (s_q.seen && !lnk.keep) ? 1'b0 : lnk.bit_in;
      if (lnk.coll_in && !s_q.seen) begin
        s_d.seen = 1'b1;
        if (num <= `RFCM_POS_RANGE) begin
          s_d.inv = 1'b0;
          s_d.pos = num[4:0];
        end
      end
    end
  end
  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '{6'h00, 1'b0, `RFCM_COLL_INV_RST, `RFCM_COLL_POS_RST,
               1'b0, 1'b0};
    end else begin
      s_q <= s_d;
    end
  end
  assign lnk.out_valid = s_q.ovalid;
  assign lnk.out_bit   = s_q.obit;
  assign lnk.inv       = s_q.inv;
  assign lnk.pos       = s_q.pos;
  property p_clear_after;
    @(posedge clk_sys) disable iff (rst)
    (s_q.seen && !lnk.keep && lnk.bit_valid && !lnk.frame_start)
      |=> (lnk.out_valid && !lnk.out_bit);
  endproperty
  a_clear_after: assert property (p_clear_after)
    else $error("bit after collision not cleared");
  property p_first_pos;
    @(posedge clk_sys) disable iff (rst)
    (s_q.cnt == 6'h00 && lnk.bit_valid && lnk.coll_in && !s_q.seen
     && !lnk.frame_start) |=> (!lnk.inv && lnk.pos == 5'h01);
  endproperty
  a_first_pos: assert property (p_first_pos)
    else $error("collision on first bit misreported");
  property p_start_inv;
    @(posedge clk_sys) disable iff (rst)
    lnk.frame_start |=> lnk.inv;
  endproperty
  a_start_inv: assert property (p_start_inv)
    else $error("position valid without collision");
endmodule // rfcm_coll_trk

// ==== hdl/rfcm_crc_unit.sv ====
// Standalone checksum engine with seed and bit order choice
`timescale 1ns/1ps
`include "rfcm_map.svh"
module rfcm_crc_unit (
  input wire logic clk_sys,
  input wire logic rst,
  rfcm_link_if.crc lnk
);
  import rfcm_pkg::*;
  rfcm_crc_s s_q;    // Registered state
  rfcm_crc_s s_d;    // Next state
  logic [15:0] nxt;  // Checksum after this byte
  // One byte through the checksum, either bit order
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] d,
                                           input logic hi);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (hi) begin
        r = (r[15] ^ d[7-i]) ? ((r << 1) ^ `RFCM_POLY_HIGH) : (r << 1);
      end else begin
        r = (r[0] ^ d[i]) ? ((r >> 1) ^ `RFCM_POLY_LOW) : (r >> 1);
      end
    end
    return r;
  endfunction
  // Mirror a 16 bit word
  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15-i];
    end
    return r;
  endfunction
  // Next state of the engine
  always_comb begin
    s_d = s_q;
    nxt = crc_byte(s_q.crc, lnk.crc_data, s_q.high);
    if (lnk.crc_start) begin
      s_d.crc  = lnk.crc_seed;
      s_d.high = lnk.crc_req_hi && !lnk.rf_busy;
      s_d.res  = lnk.crc_seed;
    end else if (lnk.crc_valid) begin
      s_d.crc = nxt;
      s_d.res = s_q.high ? rev16(nxt) : nxt;
    end
  end
  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '{1'b0, `RFCM_SEED_0, `RFCM_SEED_0};
    end else begin
      s_q <= s_d;
    end
  end
  assign lnk.crc_result = s_q.res;
  property p_seed;
    @(posedge clk_sys) disable iff (rst)
    lnk.crc_start |=> (s_q.crc == $past(lnk.crc_seed));
  endproperty
  a_seed: assert property (p_seed)
    else $error("checksum not preset from seed");
  property p_rf_ignore;
    @(posedge clk_sys) disable iff (rst)
    (lnk.crc_start && lnk.rf_busy) |=> !s_q.high;
  endproperty
  a_rf_ignore: assert property (p_rf_ignore)
    else $error("bit order applied during RF exchange");
  property p_reversed;
    @(posedge clk_sys) disable iff (rst)
    (s_q.high && lnk.crc_valid && !lnk.crc_start)
      |=> (lnk.crc_result == rev16(s_q.crc));
  endproperty
  a_reversed: assert property (p_reversed)
    else $error("result not reversed in high bit order");
endmodule // rfcm_crc_unit

// ==== hdl/rfcm_link_if.sv ====
// Signals between the register block and its two helpers
`timescale 1ns/1ps
interface rfcm_link_if;
  logic        keep;        // Keep bits after collision
  logic        frame_start; // New received frame
  logic        bit_valid;   // Received data bit strobe
  logic        bit_in;      // Received data bit
  logic        coll_in;     // Collision on this bit
  logic        out_valid;   // Stored bit strobe
  logic        out_bit;     // Stored bit
  logic        inv;         // Position not valid
  logic [4:0]  pos;         // First collision position
  logic        crc_start;   // Standalone checksum start
  logic        crc_req_hi;  // High bit first requested
  logic        rf_busy;     // RF exchange in progress
  logic [15:0] crc_seed;    // Selected seed
  logic        crc_valid;   // Data byte strobe
  logic [7:0]  crc_data;    // Data byte
  logic [15:0] crc_result;  // Result register
  modport host (output keep, frame_start, bit_valid, bit_in, coll_in,
                crc_start, crc_req_hi, rf_busy, crc_seed, crc_valid,
                crc_data,
                input out_valid, out_bit, inv, pos, crc_result);
  modport coll (input keep, frame_start, bit_valid, bit_in, coll_in,
                output out_valid, out_bit, inv, pos);
  modport crc  (input crc_start, crc_req_hi, rf_busy, crc_seed,
                crc_valid, crc_data,
                output crc_result);
endinterface

// ==== hdl/rfcm_map.svh ====
// Register offsets, field positions, reset values and constants
`ifndef RFCM_MAP_SVH
`define RFCM_MAP_SVH
`define RFCM_ADDR_MODE      16'h6301
`define RFCM_ADDR_COLL      16'h633E
`define RFCM_MODE_RST       8'h3B
`define RFCM_MODE_CRC_HIGH  7
`define RFCM_MODE_SYNC      6
`define RFCM_MODE_TX_WAIT   5
`define RFCM_MODE_RX_WAIT   4
`define RFCM_MODE_POL       3
`define RFCM_MODE_MDET_OFF  2
`define RFCM_MODE_SEED_HI   1
`define RFCM_MODE_SEED_LO   0
`define RFCM_COLL_KEEP      7
`define RFCM_COLL_INVALID   5
`define RFCM_COLL_KEEP_RST  1'b1
`define RFCM_COLL_INV_RST   1'b1
`define RFCM_COLL_POS_RST   5'h00
`define RFCM_POS_RANGE      6'h20
`define RFCM_CNT_MAX        6'h3F
`define RFCM_SYNC_BYTE      8'hF0
`define RFCM_SEED_0         16'h0000
`define RFCM_SEED_1         16'h6363
`define RFCM_SEED_2         16'hA671
`define RFCM_SEED_3         16'hFFFF
`define RFCM_POLY_LOW       16'h8408
`define RFCM_POLY_HIGH      16'h1021
`define RFCM_READ_NONE      8'h00
`endif

// ==== hdl/rfcm_pkg.sv ====
// Types shared by the collision and mode register block
package rfcm_pkg;
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_FIELD = 2'b01,
    TX_SYNC  = 2'b10,
    TX_RUN   = 2'b11
  } rfcm_tx_e;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_HUNT = 2'b01,
    RX_ON   = 2'b10
  } rfcm_rx_e;
  typedef struct packed {
    logic [7:0] mode;
    logic       keep;
    logic [7:0] rdata;
    rfcm_tx_e   tx;
    rfcm_rx_e   rx;
    logic       rxw_pend;
    logic       rxw_go;
    logic       sec_act;
    logic       env_n;
    logic       mdet_en;
  } rfcm_top_s;
  typedef struct packed {
    logic [5:0] cnt;
    logic       seen;
    logic       inv;
    logic [4:0] pos;
    logic       ovalid;
    logic       obit;
  } rfcm_coll_s;
  typedef struct packed {
    logic        high;
    logic [15:0] crc;
    logic [15:0] res;
  } rfcm_crc_s;
endpackage

// ==== hdl/rfcm_top.sv ====
// Collision report and general mode registers with their logic
// Overview of operation
// - Keep control low clears bits after collision
// - Invalid flag set without collision or overrange
// - Report first collided data bit position
// - High bit order computes and reverses result
// - Bit order ignored during RF exchange
// - Sync mode hunts F0h, prepends F0h
// - Transmit waits for own field when asked
// - Receive wait counter waits external field
// - Polarity control selects secure input level
// - Envelope signal always coded active low
// - Detector off control disables mode detector
// - Seed select presets standalone checksum
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "rfcm_map.svh"
module rfcm_top (
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic [15:0] REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output      logic [7:0]  REG_RDATA,
  input  wire logic        INITIATOR,
  input  wire logic        DRV1_FIELD_EN,
  input  wire logic        DRV2_FIELD_EN,
  input  wire logic        EXT_FIELD_DET,
  input  wire logic        TX_START_REQ,
  input  wire logic        TX_END,
  output      logic        TX_SYNC_VALID,
  output      logic [7:0]  TX_SYNC_BYTE,
  input  wire logic        TX_SYNC_READY,
  output      logic        TX_ACTIVE,
  input  wire logic        RX_START_REQ,
  input  wire logic        RX_END,
  input  wire logic        RX_BYTE_VALID,
  input  wire logic [7:0]  RX_BYTE,
  output      logic        RX_ACTIVE,
  input  wire logic        RX_FRAME_START,
  input  wire logic        RX_BIT_VALID,
  input  wire logic        RX_BIT,
  input  wire logic        RX_BIT_COLL,
  output      logic        RX_STORE_VALID,
  output      logic        RX_STORE_BIT,
  input  wire logic        RX_WAIT_REQ,
  output      logic        RX_WAIT_GO,
  input  wire logic        SEC_SIG_IN,
  output      logic        SEC_SIG_ACTIVE,
  output      logic        ENVELOPE_N,
  input  wire logic        AUTOCOLL_ACTIVE,
  output      logic        MODE_DET_EN,
  input  wire logic        RF_BUSY,
  input  wire logic        CRC_START,
  input  wire logic        CRC_DATA_VALID,
  input  wire logic [7:0]  CRC_DATA,
  output      logic [15:0] CRC_RESULT
);
  import rfcm_pkg::*;

  rfcm_top_s   s_q;      // Registered state
  rfcm_top_s   s_d;      // Next state
  rfcm_link_if lnk ();   // Link to the helpers
  logic        field;    // Own field from any driver
  logic        sync_on;  // Sync byte mode
  logic        tx_hold;  // Transmit must wait for field
  logic        rxw_hold; // Receive wait needs outside field
  logic        sec_lvl;  // Secure input seen as active
  logic [7:0]  coll_rd;  // Collision register read value

  // Seed value for a two bit selection
  function automatic logic [15:0] seed_of(input logic [1:0] sel);
    case (sel)
      2'b00:   seed_of = `RFCM_SEED_0;
      2'b01:   seed_of = `RFCM_SEED_1;
      2'b10:   seed_of = `RFCM_SEED_2;
      default: seed_of = `RFCM_SEED_3;
    endcase
  endfunction

  // Helpers
  rfcm_coll_trk u_coll (
    .clk_sys (CLK_SYS),
    .rst     (RST),
    .lnk     (lnk.coll)
  );
  rfcm_crc_unit u_crc (
    .clk_sys (CLK_SYS),
    .rst     (RST),
    .lnk     (lnk.crc)
  );

  // Drive the link towards the helpers
  always_comb begin
    lnk.keep        = s_q.keep;
    lnk.frame_start = RX_FRAME_START;
    lnk.bit_valid   = RX_BIT_VALID && (s_q.rx == RX_ON);
    lnk.bit_in      = RX_BIT;
    lnk.coll_in     = RX_BIT_COLL;
    lnk.crc_start   = CRC_START;
    lnk.crc_req_hi  = s_q.mode[`RFCM_MODE_CRC_HIGH];
    lnk.rf_busy     = RF_BUSY;
    lnk.crc_seed    = seed_of(s_q.mode[`RFCM_MODE_SEED_HI:
                                       `RFCM_MODE_SEED_LO]);
    lnk.crc_valid   = CRC_DATA_VALID;
    lnk.crc_data    = CRC_DATA;
  end

  // Decodes of mode bits and pins
  always_comb begin
    field    = DRV1_FIELD_EN || DRV2_FIELD_EN;
    sync_on  = s_q.mode[`RFCM_MODE_SYNC];
    tx_hold  = s_q.mode[`RFCM_MODE_TX_WAIT] && INITIATOR
               && !field;
    rxw_hold = s_q.mode[`RFCM_MODE_RX_WAIT] && !INITIATOR
               && !EXT_FIELD_DET;
    sec_lvl  = s_q.mode[`RFCM_MODE_POL] ? SEC_SIG_IN
               : !SEC_SIG_IN;
    coll_rd  = 8'h00;
    coll_rd[`RFCM_COLL_KEEP]    = s_q.keep;
    coll_rd[`RFCM_COLL_INVALID] = lnk.inv;
    coll_rd[4:0]                = lnk.pos;
  end

  // Next state of registers and sequencers
  always_comb begin
    s_d = s_q;
    // Register writes; only the keep bit of the report is writable
    if (REG_WR) begin
      if (REG_ADDR == `RFCM_ADDR_MODE) begin
        s_d.mode = REG_WDATA;
      end else if (REG_ADDR == `RFCM_ADDR_COLL) begin
        s_d.keep = REG_WDATA[`RFCM_COLL_KEEP];
      end
    end
    // Register reads, answered next cycle
    if (REG_RD) begin
      case (REG_ADDR)
        `RFCM_ADDR_MODE: s_d.rdata = s_q.mode;
        `RFCM_ADDR_COLL: s_d.rdata = coll_rd;
        default:         s_d.rdata = `RFCM_READ_NONE;
      endcase
    end else begin
      s_d.rdata = `RFCM_READ_NONE;
    end
    // Transmit sequencer
    case (s_q.tx)
      TX_IDLE: begin
        if (TX_START_REQ) begin
          if (tx_hold) begin
            s_d.tx = TX_FIELD;
          end else if (sync_on) begin
            s_d.tx = TX_SYNC;
          end else begin
            s_d.tx = TX_RUN;
          end
        end
      end
      TX_FIELD: begin
        // Hold until a driver makes the field
        if (!tx_hold) begin
          s_d.tx = sync_on ? TX_SYNC : TX_RUN;
        end
      end
      TX_SYNC: begin
        // Sync byte goes out before data
        if (TX_SYNC_READY) begin
          s_d.tx = TX_RUN;
        end
      end
      TX_RUN: begin
        if (TX_END) begin
          s_d.tx = TX_IDLE;
        end
      end
      default: s_d.tx = TX_IDLE;
    endcase
    if (TX_END) begin
      s_d.tx = TX_IDLE;
    end
    // Receive sequencer
    case (s_q.rx)
      RX_IDLE: begin
        if (RX_START_REQ) begin
          s_d.rx = sync_on ? RX_HUNT : RX_ON;
        end
      end
      RX_HUNT: begin
        // Receiver stays off until the sync byte
        if (RX_BYTE_VALID && RX_BYTE == `RFCM_SYNC_BYTE) begin
          s_d.rx = RX_ON;
        end
      end
      RX_ON: begin
        if (RX_END) begin
          s_d.rx = RX_IDLE;
        end
      end
      default: s_d.rx = RX_IDLE;
    endcase
    if (RX_END) begin
      s_d.rx = RX_IDLE;
    end
    // Receive wait counter start
    s_d.rxw_go = 1'b0;
    if (RX_WAIT_REQ || s_q.rxw_pend) begin
      if (rxw_hold) begin
        s_d.rxw_pend = 1'b1;
      end else begin
        s_d.rxw_pend = 1'b0;
        s_d.rxw_go   = 1'b1;
      end
    end
    // Secure input, envelope and detector enable
    s_d.sec_act = sec_lvl;
    s_d.env_n   = !sec_lvl;
    s_d.mdet_en = AUTOCOLL_ACTIVE
                  && !s_q.mode[`RFCM_MODE_MDET_OFF];
  end

  // State register
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      s_q <= '{`RFCM_MODE_RST, `RFCM_COLL_KEEP_RST, `RFCM_READ_NONE,
               TX_IDLE, RX_IDLE, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign REG_RDATA      = s_q.rdata;
  assign TX_SYNC_VALID  = (s_q.tx == TX_SYNC);
  assign TX_SYNC_BYTE   = `RFCM_SYNC_BYTE;
  assign TX_ACTIVE      = (s_q.tx == TX_RUN);
  assign RX_ACTIVE      = (s_q.rx == RX_ON);
  assign RX_STORE_VALID = lnk.out_valid;
  assign RX_STORE_BIT   = lnk.out_bit;
  assign RX_WAIT_GO     = s_q.rxw_go;
  assign SEC_SIG_ACTIVE = s_q.sec_act;
  assign ENVELOPE_N     = s_q.env_n;
  assign MODE_DET_EN    = s_q.mdet_en;
  assign CRC_RESULT     = lnk.crc_result;

  property p_rsvd_zero;
    @(posedge CLK_SYS) disable iff (RST)
    (REG_RD && REG_ADDR == `RFCM_ADDR_COLL) |=> !REG_RDATA[6];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bit read as one");
  property p_ro_write;
    @(posedge CLK_SYS) disable iff (RST)
    (REG_WR && REG_ADDR == `RFCM_ADDR_COLL && !RX_BIT_VALID
     && !RX_FRAME_START) |=> ($stable(lnk.pos) && $stable(lnk.inv));
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("status field changed by a write");
  property p_sync_hunt;
    @(posedge CLK_SYS) disable iff (RST)
    (s_q.rx == RX_HUNT
     && !(RX_BYTE_VALID && RX_BYTE == `RFCM_SYNC_BYTE))
      |=> !RX_ACTIVE;
  endproperty
  a_sync_hunt: assert property (p_sync_hunt)
    else $error("receiver on before sync byte");
  property p_sync_tx;
    @(posedge CLK_SYS) disable iff (RST)
    (s_q.tx == TX_IDLE && TX_START_REQ && !TX_END && sync_on
     && !tx_hold)
      |=> (TX_SYNC_VALID && TX_SYNC_BYTE == `RFCM_SYNC_BYTE);
  endproperty
  a_sync_tx: assert property (p_sync_tx)
    else $error("sync byte not offered");
  property p_tx_field;
    @(posedge CLK_SYS) disable iff (RST)
    (s_q.mode[`RFCM_MODE_TX_WAIT] && INITIATOR && !DRV1_FIELD_EN
     && !DRV2_FIELD_EN && s_q.tx != TX_RUN) |=> !TX_ACTIVE;
  endproperty
  a_tx_field: assert property (p_tx_field)
    else $error("transmitter started without own field");
  property p_rxw_field;
    @(posedge CLK_SYS) disable iff (RST)
    (s_q.mode[`RFCM_MODE_RX_WAIT] && !INITIATOR && !EXT_FIELD_DET)
      |=> !RX_WAIT_GO;
  endproperty
  a_rxw_field: assert property (p_rxw_field)
    else $error("wait counter started without field");
  property p_polarity;
    @(posedge CLK_SYS) disable iff (RST)
    ##1 SEC_SIG_ACTIVE
        == ($past(SEC_SIG_IN) == $past(s_q.mode[`RFCM_MODE_POL]));
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("secure input polarity wrong");
  property p_envelope;
    @(posedge CLK_SYS) disable iff (RST)
    ##1 ENVELOPE_N
        == ($past(SEC_SIG_IN) != $past(s_q.mode[`RFCM_MODE_POL]));
  endproperty
  a_envelope: assert property (p_envelope)
    else $error("envelope not active low");
  property p_mdet;
    @(posedge CLK_SYS) disable iff (RST)
    s_q.mode[`RFCM_MODE_MDET_OFF] |=> !MODE_DET_EN;
  endproperty
  a_mdet: assert property (p_mdet)
    else $error("mode detector on while switched off");
endmodule // rfcm_top

// ==== verif/rfcm_peer.sv ====
// Remote peer model: received bits, received bytes, external field
`timescale 1ns/1ps
module rfcm_peer (
  input  wire logic       clk,
  output      logic       frame_start,
  output      logic       bit_valid,
  output      logic       bit_val,
  output      logic       bit_coll,
  output      logic       byte_valid,
  output      logic [7:0] byte_val,
  output      logic       ext_field
);
  // Quiet lines at time zero
  initial begin
    frame_start = 1'b0;
    bit_valid   = 1'b0;
    bit_val     = 1'b0;
    bit_coll    = 1'b0;
    byte_valid  = 1'b0;
    byte_val    = 8'h00;
    ext_field   = 1'b0;
  end
  // Frame of n one bits, collision on bit at, none if 0
  task automatic send_frame(input int n, input int at);
    @(posedge clk) frame_start <= 1'b1;
    for (int i = 1; i <= n; i++) begin
      @(posedge clk);
      frame_start <= 1'b0;
      bit_valid   <= 1'b1;
      bit_val     <= 1'b1;
      bit_coll    <= (i == at);
    end
    @(posedge clk);
    // Released data line shows the inverse of the last bit
    bit_valid <= 1'b0;
    bit_val   <= 1'b0;
    bit_coll  <= 1'b0;
  endtask
  // One decoded byte, then the inverse value
  task automatic send_byte(input logic [7:0] b);
    @(posedge clk);
    byte_valid <= 1'b1;
    byte_val   <= b;
    @(posedge clk);
    byte_valid <= 1'b0;
    byte_val   <= ~b;
  endtask
  // External field on or off
  task automatic set_field(input logic v);
    @(posedge clk) ext_field <= v;
  endtask
endmodule // rfcm_peer

// ==== verif/test_rf_collision_and_mode_regs.sv ====
// Self-checking bench for the collision and mode registers
`timescale 1ns/1ps
`include "rfcm_map.svh"
module test_rf_collision_and_mode_regs;
  logic        clk, rst, wr, rd, init, drv1, drv2, tx_req, tx_end;
  logic        sync_v, sync_rdy, tx_act, rx_req, rx_end, rx_act;
  logic        st_v, st_b, w_req, w_go, sec_in, sec_act, env_n;
  logic        acol, mdet, rf_busy, crc_st, crc_dv;
  logic        fs, bv, bb, bc, yv, ext;
  logic [15:0] addr, crc_res;
  logic [7:0]  wdata, rdata, sync_b, crc_d, yb;
  int          n_errors, checked, ones, gos;
  // Device under test
  rfcm_top i_dut (
    .CLK_SYS(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .INITIATOR(init),
    .DRV1_FIELD_EN(drv1), .DRV2_FIELD_EN(drv2), .EXT_FIELD_DET(ext),
    .TX_START_REQ(tx_req), .TX_END(tx_end), .TX_SYNC_VALID(sync_v),
    .TX_SYNC_BYTE(sync_b), .TX_SYNC_READY(sync_rdy),
    .TX_ACTIVE(tx_act), .RX_START_REQ(rx_req), .RX_END(rx_end),
    .RX_BYTE_VALID(yv), .RX_BYTE(yb), .RX_ACTIVE(rx_act),
    .RX_FRAME_START(fs), .RX_BIT_VALID(bv), .RX_BIT(bb),
    .RX_BIT_COLL(bc), .RX_STORE_VALID(st_v), .RX_STORE_BIT(st_b),
    .RX_WAIT_REQ(w_req), .RX_WAIT_GO(w_go), .SEC_SIG_IN(sec_in),
    .SEC_SIG_ACTIVE(sec_act), .ENVELOPE_N(env_n),
    .AUTOCOLL_ACTIVE(acol), .MODE_DET_EN(mdet), .RF_BUSY(rf_busy),
    .CRC_START(crc_st), .CRC_DATA_VALID(crc_dv), .CRC_DATA(crc_d),
    .CRC_RESULT(crc_res)
  );
  // Far side model
  rfcm_peer i_peer (
    .clk(clk), .frame_start(fs), .bit_valid(bv), .bit_val(bb),
    .bit_coll(bc), .byte_valid(yv), .byte_val(yb), .ext_field(ext)
  );
  // Clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Counts stored one bits and wait-go pulses
  always @(posedge clk) begin
    if (st_v === 1'b1 && st_b === 1'b1) ones <= ones + 1;
    if (w_go === 1'b1) gos <= gos + 1;
  end
  // Compare and report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Wait n edges, then settle
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Register write, one cycle
  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk) wr <= 1'b0;
  endtask
  // Register read, masked compare in the answer cycle
  task automatic rchk(input logic [15:0] a, input logic [7:0] e,
                      input logic [7:0] m);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    #1 chk(16'(rdata & m), 16'(e));
  endtask
  // Checksum reference for one byte
  function automatic logic [15:0] crc_ref(input logic [15:0] s,
                                          input logic [7:0] d,
                                          input logic h);
    logic [15:0] c;
    c = h ? s ^ {d, 8'h00} : s ^ {8'h00, d};
    for (int b = 0; b < 8; b++)
      if (h) c = c[15] ? (c << 1) ^ `RFCM_POLY_HIGH : c << 1;
      else   c = c[0] ? (c >> 1) ^ `RFCM_POLY_LOW : c >> 1;
    return h ? {<<{c}} : c;
  endfunction
  // Reset values, unmapped place, read-only fields
  task automatic s_regs;
    rchk(`RFCM_ADDR_MODE, `RFCM_MODE_RST, 8'hFF);
    rchk(`RFCM_ADDR_COLL, 8'hA0, 8'hFF);
    wreg(16'h6300, 8'h55);
    rchk(16'h6300, 8'h00, 8'hFF);
    rchk(`RFCM_ADDR_MODE, `RFCM_MODE_RST, 8'hFF);
    wreg(`RFCM_ADDR_COLL, 8'h5F);
    rchk(`RFCM_ADDR_COLL, 8'h20, 8'hFF);
  endtask
  // Collision position, invalid flag, clearing after collision
  task automatic s_coll;
    int         n[6] = '{12, 12, 33, 34, 10, 12};
    int         at[6] = '{5, 8, 32, 33, 0, 1};
    int         o[6] = '{5, 12, 33, 34, 10, 1};
    logic [7:0] k[6] = '{8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h5F};
    logic [7:0] e[6] = '{8'h05, 8'h88, 8'h80, 8'hA0, 8'hA0, 8'h01};
    logic [7:0] m[6] = '{8'hFF, 8'hFF, 8'hFF, 8'hE0, 8'hE0, 8'hFF};
    @(posedge clk) rx_req <= 1'b1;
    @(posedge clk) rx_req <= 1'b0;
    tk(1);
    chk(16'(rx_act), 16'h0001);
    for (int i = 0; i < 6; i++) begin
      wreg(`RFCM_ADDR_COLL, k[i]);
      ones = 0;
      i_peer.send_frame(n[i], at[i]);
      tk(2);
      chk(16'(ones), 16'(o[i]));
      rchk(`RFCM_ADDR_COLL, e[i], m[i]);
    end
    // Keep bit back to one outside anticollision
    wreg(`RFCM_ADDR_COLL, 8'hFF);
    rchk(`RFCM_ADDR_COLL, 8'h80, 8'h80);
    @(posedge clk) rx_end <= 1'b1;
    @(posedge clk) rx_end <= 1'b0;
  endtask
  // Sync hunt and sync prefix, transmit waits for own field
  task automatic s_sync;
    wreg(`RFCM_ADDR_MODE, 8'h7B);
    init <= 1'b1;
    @(posedge clk) rx_req <= 1'b1;
    @(posedge clk) rx_req <= 1'b0;
    i_peer.send_byte(8'h55);
    tk(3);
    chk(16'(rx_act), 16'h0000);
    i_peer.send_byte(`RFCM_SYNC_BYTE);
    tk(2);
    chk(16'(rx_act), 16'h0001);
    @(posedge clk) tx_req <= 1'b1;
    @(posedge clk) tx_req <= 1'b0;
    tk(3);
    chk(16'({sync_v, tx_act}), 16'h0000);
    @(posedge clk) drv2 <= 1'b1;
    tk(2);
    chk({6'h00, sync_v, tx_act, sync_b}, 16'h02F0);
    @(posedge clk) sync_rdy <= 1'b1;
    @(posedge clk) sync_rdy <= 1'b0;
    tk(1);
    chk(16'({sync_v, tx_act}), 16'h0001);
    @(posedge clk) tx_end <= 1'b1;
    @(posedge clk) tx_end <= 1'b0;
    tk(1);
    chk(16'(tx_act), 16'h0000);
  endtask
  // Receive-wait counter held until external field in card mode
  task automatic s_wait;
    wreg(`RFCM_ADDR_MODE, 8'h3B);
    init <= 1'b0;
    gos = 0;
    @(posedge clk) w_req <= 1'b1;
    @(posedge clk) w_req <= 1'b0;
    tk(4);
    chk(16'(gos), 16'h0000);
    i_peer.set_field(1'b1);
    tk(3);
    chk(16'(gos), 16'h0001);
    i_peer.set_field(1'b0);
    wreg(`RFCM_ADDR_MODE, 8'h2B);
    @(posedge clk) w_req <= 1'b1;
    @(posedge clk) w_req <= 1'b0;
    tk(2);
    chk(16'(gos), 16'h0002);
  endtask
  // Secure input polarity, envelope active low, mode detector
  task automatic s_misc;
    for (int i = 0; i < 4; i++) begin
      wreg(`RFCM_ADDR_MODE, i[1] ? 8'h3B : 8'h33);
      @(posedge clk) sec_in <= i[0];
      tk(2);
      chk(16'({sec_act, env_n}),
          16'({i[1] == i[0], i[1] != i[0]}));
    end
    @(posedge clk) acol <= 1'b1;
    wreg(`RFCM_ADDR_MODE, 8'h3B);
    tk(2);
    chk(16'(mdet), 16'h0001);
    wreg(`RFCM_ADDR_MODE, 8'h3F);
    tk(2);
    chk(16'(mdet), 16'h0000);
  endtask
  // Seeds, high bit order, order ignored while RF busy
  task automatic s_crc;
    logic [15:0] sd[4] = '{`RFCM_SEED_0, `RFCM_SEED_1, `RFCM_SEED_2,
                           `RFCM_SEED_3};
    logic [1:0]  s;
    for (int i = 0; i < 6; i++) begin
      s = (i > 3) ? 2'b11 : 2'(i);
      wreg(`RFCM_ADDR_MODE, {i > 3, 5'b01110, s});
      @(posedge clk);
      rf_busy <= (i == 5);
      crc_st  <= 1'b1;
      @(posedge clk);
      crc_st <= 1'b0;
      crc_dv <= 1'b1;
      crc_d  <= 8'hA5;
      @(posedge clk) crc_dv <= 1'b0;
      tk(2);
      chk(crc_res, crc_ref(sd[s], 8'hA5, i == 4));
    end
  endtask
  // Verdict and end of run
  task automatic summarize;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence
  initial begin
    {rst, wr, rd, init, drv1, drv2, tx_req, tx_end, sync_rdy} = 9'h100;
    {rx_req, rx_end, w_req, sec_in, acol, rf_busy, crc_st, crc_dv} = 0;
    {addr, wdata, crc_d} = 0;
    {n_errors, checked, ones, gos} = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    s_regs;
    s_coll;
    s_sync;
    s_wait;
    s_misc;
    s_crc;
    summarize;
  end
  // Hang guard
  initial begin
    #200000 n_errors++;
    summarize;
  end
endmodule // test_rf_collision_and_mode_regs
